// ---- shared/ics_defines.vh ----
// Constants for the indicator and contact scanner: register offsets,
// field positions, reset values and timing counts.
// Assumes a 125 MHz system clock and a 32-bit classic Wishbone bus.
`ifndef ICS_DEFINES_VH
`define ICS_DEFINES_VH

// Register byte offsets
`define ICS_OFF_PATTERN 8'h00
`define ICS_OFF_SHADOW 8'h04
`define ICS_OFF_CTRL 8'h08
`define ICS_OFF_CONTACT 8'h0c
`define ICS_OFF_STATUS 8'h10
`define ICS_OFF_MASK 8'h14

// Control register fields
`define ICS_CTRL_COMMIT 0
`define ICS_CTRL_POLL_EN 1
`define ICS_CTRL_READ_LEFT 2
`define ICS_CTRL_READ_RIGHT 3
`define ICS_CTRL_BOOT_DONE 4
`define ICS_CTRL_DARK_SEEN 5

// Status / mask fields
`define ICS_ST_CHANGE 0
`define ICS_ST_DIRECT 1

// Indicator index of shared pins (0-based)
`define ICS_LEFT_BIT 5
`define ICS_RIGHT_BIT 2

// Reset values
`define ICS_PATTERN_RST 6'h00
`define ICS_MASK_RST 2'h0

// Timing
`define ICS_CLK_HZ 125000000
`define ICS_POLL_MS 50
`define ICS_POLL_CYCLES ((`ICS_CLK_HZ / 1000) * `ICS_POLL_MS)
`define ICS_FLOAT_CYCLES 4
`define ICS_SETTLE_NS 24
`define ICS_CLK_NS 8
`define ICS_SETTLE_CYCLES ((`ICS_SETTLE_NS + `ICS_CLK_NS - 1) / `ICS_CLK_NS)

`endif

// ---- core/ics_pin_scan.v ----
// Scan sequencer for the two pins shared by an indicator and a contact.
// Assumes pin inputs are synchronous to clk; the caller holds pins dark.
`timescale 1ns/1ps
`include "ics_defines.vh"

module ics_pin_scan #(
    parameter FLOAT_CYCLES = `ICS_FLOAT_CYCLES
)
(
    input wire clk,
    input wire reset,
    input wire start,
    input wire leftPinIn,
    input wire rightPinIn,
    output reg scanBusy,
    output reg sampleValid,
    output reg leftClosed,
    output reg rightClosed
);

localparam ST_IDLE = 1'b0;
localparam ST_FLOAT = 1'b1;

reg stateReg;
reg [3:0] cntReg;

////////////////////////////////////////////////////////////////////////
// Float the pins a few cycles, then sample; a closed switch pulls low
always @(posedge clk)
begin
    if (reset)
    begin
        stateReg <= ST_IDLE;
        cntReg <= 4'h0;
        scanBusy <= 1'b0;
        sampleValid <= 1'b0;
        leftClosed <= 1'b0;
        rightClosed <= 1'b0;
    end
    else
    begin
        sampleValid <= 1'b0;
        case (stateReg)
            ST_IDLE:
            begin
                if (start)
                begin
                    stateReg <= ST_FLOAT;
                    scanBusy <= 1'b1;
                    cntReg <= FLOAT_CYCLES[3:0] - 4'h1;
                end
            end
            default:
            begin
                if (cntReg == 4'h0)
                begin
                    // Short window only, so the dark gap is invisible
                    leftClosed <= ~leftPinIn;
                    rightClosed <= ~rightPinIn;
                    sampleValid <= 1'b1;
                    scanBusy <= 1'b0;
                    stateReg <= ST_IDLE;
                end
                else
                begin
                    cntReg <= cntReg - 4'h1;
                end
            end
        endcase
    end
end

endmodule // ics_pin_scan

// ---- core/ics_indicator_scanner.v ----
// Six indicator outputs with shadow/commit, contact switch scanning on
// two shared pins, 50 ms background polling and a change interrupt.
// Assumes a classic Wishbone master, inputs synchronous to clk, and an
// external pin model that resolves each pin from its output enable.
`timescale 1ns/1ps
`include "ics_defines.vh"

// Summary of operation
// - Six-bit pattern; bit 0 lights indicator one, cleared bits turn off.
// - Shadow bits reach pins only when a commit copies them out.
// - Committing one changed shadow bit leaves other indicators alone.
// - Shared pins float briefly as inputs to sample switches, then restore.
// - An indicator is switched off by floating its pin, never driving low.
// - Left switch shares indicator six, right shares three; glow allowed.
// - Never drive a shared pin low while its switch may close.
// - With polling enabled, sample both switches every 50 ms; keep flags.
// - A polled change in either switch raises one change event.
// - Boot-dark setting from stored byte keeps pins inactive while booting.
module ics_indicator_scanner #(
    parameter NUM_IND = 6,
    parameter POLL_CYCLES = `ICS_POLL_CYCLES
)
(
    input wire clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire bootDarkByte,
    input wire bootDarkValid,
    input wire [NUM_IND-1:0] pinIn,
    output reg [NUM_IND-1:0] pinOut,
    output reg [NUM_IND-1:0] pinOe,
    output reg irq
);

reg [NUM_IND-1:0] shadowReg;
reg [NUM_IND-1:0] patternReg;
reg pollEnReg;
reg bootDoneReg;
reg darkBootReg;
reg darkSeenReg;
reg leftFlagReg;
reg rightFlagReg;
reg [1:0] statusReg;
reg [1:0] maskReg;
reg [31:0] pollCntReg;
reg scanFromPoll;
reg scanStart;
reg leftDirectReg;
reg rightDirectReg;
reg [1:0] statusNext;
reg [1:0] maskNext;
reg pollPendReg;
reg [31:0] patternView;
reg [31:0] shadowView;
reg [31:0] ctrlView;
reg [31:0] contactView;
reg [31:0] statusView;
wire scanBusy;
wire sampleValid;
wire leftClosed;
wire rightClosed;
wire busReq;
wire wrStb;
wire pollTick;
wire changeEvt;
wire directEvt;
wire darkNow;

// Contact register layout: polled flags low, direct flags above
localparam CONTACT_LEFT_POLL = 0;
localparam CONTACT_RIGHT_POLL = 1;
localparam CONTACT_LEFT_DIRECT = 2;
localparam CONTACT_RIGHT_DIRECT = 3;

// Bus strobes, poll tick and the two kinds of scan result
assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wrStb = busReq & wb_we_i & wb_sel_i[0];
assign pollTick = pollEnReg && (pollCntReg == POLL_CYCLES - 1);
assign changeEvt = sampleValid & scanFromPoll &
    ((leftClosed != leftFlagReg) | (rightClosed != rightFlagReg));
assign directEvt = sampleValid & ~scanFromPoll;
assign darkNow = darkBootReg & ~bootDoneReg;

////////////////////////////////////////////////////////////////////////
// Scan sequencer for the shared pins
ics_pin_scan #(
    .FLOAT_CYCLES(`ICS_FLOAT_CYCLES)
) u_scan (
    .clk(clk),
    .reset(reset),
    .start(scanStart),
    .leftPinIn(pinIn[`ICS_LEFT_BIT]),
    .rightPinIn(pinIn[`ICS_RIGHT_BIT]),
    .scanBusy(scanBusy),
    .sampleValid(sampleValid),
    .leftClosed(leftClosed),
    .rightClosed(rightClosed)
);

////////////////////////////////////////////////////////////////////////
// Read views placed by field position from the header and the contact localparams;
// the mux below picks a word and pads the mask word itself; unused bits read zero
always @*
begin
    patternView = 32'h0;
    patternView[NUM_IND-1:0] = patternReg;
    shadowView = 32'h0;
    shadowView[NUM_IND-1:0] = shadowReg;
    // Commit is write-only, so its position reads back scan busy
    ctrlView = 32'h0;
    ctrlView[`ICS_CTRL_COMMIT] = scanBusy;
    ctrlView[`ICS_CTRL_POLL_EN] = pollEnReg;
    ctrlView[`ICS_CTRL_BOOT_DONE] = bootDoneReg;
    ctrlView[`ICS_CTRL_DARK_SEEN] = darkSeenReg;
    contactView = 32'h0;
    contactView[CONTACT_LEFT_POLL] = leftFlagReg;
    contactView[CONTACT_RIGHT_POLL] = rightFlagReg;
    contactView[CONTACT_LEFT_DIRECT] = leftDirectReg;
    contactView[CONTACT_RIGHT_DIRECT] = rightDirectReg;
    statusView = 32'h0;
    statusView[`ICS_ST_CHANGE] = statusReg[`ICS_ST_CHANGE];
    statusView[`ICS_ST_DIRECT] = statusReg[`ICS_ST_DIRECT];
end

////////////////////////////////////////////////////////////////////////
// Wishbone slave: one-cycle ack, unmapped reads return zero
always @(posedge clk)
begin
    if (reset)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end
    else
    begin
        wb_ack_o <= busReq;
        wb_dat_o <= 32'h0;
        if (busReq & ~wb_we_i)
        begin
            if (wb_adr_i == `ICS_OFF_PATTERN)
                wb_dat_o <= patternView;
            else if (wb_adr_i == `ICS_OFF_SHADOW)
                wb_dat_o <= shadowView;
            else if (wb_adr_i == `ICS_OFF_CTRL)
                wb_dat_o <= ctrlView;
            else if (wb_adr_i == `ICS_OFF_CONTACT)
                wb_dat_o <= contactView;
            else if (wb_adr_i == `ICS_OFF_STATUS)
                wb_dat_o <= statusView;
            else if (wb_adr_i == `ICS_OFF_MASK)
                wb_dat_o <= {30'h0, maskReg};
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Pattern, shadow and control registers
always @(posedge clk)
begin
    if (reset)
    begin
        shadowReg <= `ICS_PATTERN_RST;
        patternReg <= `ICS_PATTERN_RST;
        pollEnReg <= 1'b0;
        bootDoneReg <= 1'b0;
        maskReg <= `ICS_MASK_RST;
    end
    else if (wrStb)
    begin
        if (wb_adr_i == `ICS_OFF_PATTERN)
        begin
            // Direct set writes shadow and outputs together
            shadowReg <= wb_dat_i[NUM_IND-1:0];
            patternReg <= wb_dat_i[NUM_IND-1:0];
        end
        else if (wb_adr_i == `ICS_OFF_SHADOW)
            shadowReg <= wb_dat_i[NUM_IND-1:0];
        else if (wb_adr_i == `ICS_OFF_CTRL)
        begin
            if (wb_dat_i[`ICS_CTRL_COMMIT])
                patternReg <= shadowReg;
            pollEnReg <= wb_dat_i[`ICS_CTRL_POLL_EN];
            if (wb_dat_i[`ICS_CTRL_BOOT_DONE])
                bootDoneReg <= 1'b1;
        end
        else if (wb_adr_i == `ICS_OFF_MASK)
            maskReg <= wb_dat_i[1:0];
    end
end

////////////////////////////////////////////////////////////////////////
// Boot-dark setting captured after reset release, not under reset
always @(posedge clk)
begin
    if (reset)
    begin
        darkBootReg <= 1'b0;
        darkSeenReg <= 1'b0;
    end
    else if (bootDarkValid & ~darkSeenReg)
    begin
        darkBootReg <= bootDarkByte;
        darkSeenReg <= 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////
// 50 ms poll divider and scan launch; direct reads take priority
always @(posedge clk)
begin
    if (reset)
    begin
        pollCntReg <= 32'h0;
        scanStart <= 1'b0;
        scanFromPoll <= 1'b0;
        pollPendReg <= 1'b0;
    end
    else
    begin
        scanStart <= 1'b0;
        if (!pollEnReg || pollTick)
            pollCntReg <= 32'h0;
        else
            pollCntReg <= pollCntReg + 32'h1;
        // A tick that meets a scan in flight is kept, not lost, so the
        // poll period holds even under direct reads
        if (pollTick)
            pollPendReg <= 1'b1;
        else if (!pollEnReg)
            pollPendReg <= 1'b0;
        // A direct request refused here is dropped; no done bit follows
        if (!scanBusy && !scanStart && !sampleValid)
        begin
            // Back-to-back direct reads are software's job to avoid
            if (wrStb && wb_adr_i == `ICS_OFF_CTRL &&
                (wb_dat_i[`ICS_CTRL_READ_LEFT] |
                 wb_dat_i[`ICS_CTRL_READ_RIGHT]))
            begin
                scanStart <= 1'b1;
                scanFromPoll <= 1'b0;
            end
            else if (pollTick || (pollPendReg && pollEnReg))
            begin
                scanStart <= 1'b1;
                scanFromPoll <= 1'b1;
                pollPendReg <= 1'b0;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Contact flags: polled and direct results are kept apart
always @(posedge clk)
begin
    if (reset)
    begin
        leftFlagReg <= 1'b0;
        rightFlagReg <= 1'b0;
        leftDirectReg <= 1'b0;
        rightDirectReg <= 1'b0;
    end
    else if (sampleValid & scanFromPoll)
    begin
        leftFlagReg <= leftClosed;
        rightFlagReg <= rightClosed;
    end
    else if (sampleValid)
    begin
        leftDirectReg <= leftClosed;
        rightDirectReg <= rightClosed;
    end
end

////////////////////////////////////////////////////////////////////////
// Sticky status, write one to clear; a new event beats the clear
always @*
begin
    statusNext = statusReg;
    if (wrStb && wb_adr_i == `ICS_OFF_STATUS)
        statusNext = statusReg & ~wb_dat_i[1:0];
    if (changeEvt)
        statusNext[`ICS_ST_CHANGE] = 1'b1;
    if (directEvt)
        statusNext[`ICS_ST_DIRECT] = 1'b1;
end

// Mask as it stands after this cycle's write, so irq follows at once
always @*
begin
    maskNext = maskReg;
    if (wrStb && wb_adr_i == `ICS_OFF_MASK)
        maskNext = wb_dat_i[1:0];
end

always @(posedge clk)
begin
    if (reset)
    begin
        statusReg <= 2'h0;
        irq <= 1'b0;
    end
    else
    begin
        statusReg <= statusNext;
        irq <= |(statusNext & maskNext);
    end
end

////////////////////////////////////////////////////////////////////////
// Pin drivers: lit drives high, dark floats, scan floats shared pins
genvar gi;
generate
    for (gi = 0; gi < NUM_IND; gi = gi + 1)
    begin : g_pin
        wire shared = (gi == `ICS_LEFT_BIT) || (gi == `ICS_RIGHT_BIT);
        always @(posedge clk)
        begin
            if (reset)
            begin
                pinOut[gi] <= 1'b0;
                pinOe[gi] <= 1'b0;
            end
            else
            begin
                // Never a low drive, so a closed switch draws no extra
                pinOut[gi] <= 1'b1;
                if (darkNow)
                    pinOe[gi] <= 1'b0;
                else if (shared && (scanBusy || scanStart))
                    pinOe[gi] <= 1'b0;
                else
                    pinOe[gi] <= patternReg[gi];
            end
        end
    end
endgenerate

endmodule // ics_indicator_scanner

// ---- test/ics_chk.sv ----
// Checker for the indicator scanner: bus timing and pin relations.
// Bound to the scanner top; sees only its ports.
`timescale 1ns/1ps
module ics_chk #(
    parameter NUM_IND = 6
)
(
    input wire clk,
    input wire reset,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [NUM_IND-1:0] pinOut,
    input wire [NUM_IND-1:0] pinOe,
    input wire irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [1:0] ackHist_reg;
    wire ackNear = wb_ack_o || ackHist_reg[0] || ackHist_reg[1];
    ////////////////////////////////////////////////////////////////////
    // Recent acks: register writes reach the pins up to two cycles late
    always @(posedge clk)
        ackHist_reg <= {ackHist_reg[0], wb_ack_o};
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_restore;
        ##[1:10] (pinOe[5] || wb_ack_o);
    endsequence
    property p_ack;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    property p_drive_high;
        !$past(reset) |-> pinOut == {NUM_IND{1'b1}};
    endproperty
    property p_oe_cause;
        ({pinOe[4:3], pinOe[1:0]} != {$past(pinOe[4:3]), $past(pinOe[1:0])})
            |-> ackNear;
    endproperty
    property p_scan_restore;
        $fell(pinOe[5]) && !ackNear |-> s_restore;
    endproperty
    property p_irq_fall;
        $fell(irq) |-> ackNear;
    endproperty
    a_ack: assert property (p_ack) else $error("ack not next cycle");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
    a_drive_high:
        assert property (p_drive_high) else $error("pin driven low");
    a_oe_cause:
        assert property (p_oe_cause) else $error("indicator moved alone");
    a_scan_restore:
        assert property (p_scan_restore) else $error("pin not restored");
    a_irq_fall:
        assert property (p_irq_fall) else $error("irq dropped alone");
endmodule // ics_chk

bind ics_indicator_scanner ics_chk #(.NUM_IND(NUM_IND)) ics_chk_inst (
    .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pinOut(pinOut),
    .pinOe(pinOe), .irq(irq));

// ---- test/ics_contact_model.sv ----
// Pin side model: six indicators, two contact switches to ground.
// Assumes pull-ups on the shared pins only; others float.
`timescale 1ns/1ps
module ics_contact_model (
    input wire clk,
    input wire [5:0] pinOut,
    input wire [5:0] pinOe,
    input wire leftPressed,
    input wire rightPressed,
    output logic [5:0] pinIn
);
    logic flip_reg = 1'b0;
    ////////////////////////////////////////////////////////////////////
    // Floating lines wander so a stale value is never read back
    always @(posedge clk)
        flip_reg <= ~flip_reg;
    // Closed switch grounds its line even while driven high
    always_comb
    begin
        pinIn = (pinOe & pinOut) | (~pinOe & {6{flip_reg}});
        pinIn[5] = leftPressed ? 1'b0 : (pinOe[5] ? pinOut[5] : 1'b1);
        pinIn[2] = rightPressed ? 1'b0 : (pinOe[2] ? pinOut[2] : 1'b1);
    end
endmodule // ics_contact_model

// ---- test/tb_top.sv ----
// Self-checking bench: boot dark, pattern, shadow, scans, polling.
// Assumes the scanner with a short poll period and the pin model.
`timescale 1ns/1ps
module tb_top;
    localparam int POLL = 200;
    logic clk, reset, wbCyc, wbStb, wbWe, ack, irq, leftPressed;
    logic rightPressed;
    logic darkByte, darkValid;
    logic [3:0] wbSel;
    logic [7:0] wbAdr;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [5:0] pinIn, pinOut, pinOe;
    int bad_count = 0;
    int tests_run = 0;
    int cnt;
    ics_indicator_scanner #(.POLL_CYCLES(POLL)) ics_indicator_scanner_inst (
        .clk(clk), .reset(reset), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(ack),
        .bootDarkByte(darkByte), .bootDarkValid(darkValid), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
    ics_contact_model ics_contact_model_inst (.clk(clk), .pinOut(pinOut),
        .pinOe(pinOe), .leftPressed(leftPressed),
        .rightPressed(rightPressed), .pinIn(pinIn));
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle; waits for ack, then releases
    task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbSel <= 4'hf;
        wbAdr <= a;
        wbDatW <= d;
        k = 0;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        if (ack !== 1'b1)
        begin
            $display("[ERR] %0t no ack from register bus", $time);
            bad_count++;
            conclude;
        end
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    task pins(input logic [5:0] v);
        repeat (3) @(posedge clk);
        chk({26'h0, pinOe}, {26'h0, v});
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_boot;
        bus(1, 8'h00, 32'h3f);
        pins(6'h00);
        bus(0, 8'h08, 0);
        chk(rd & 32'h30, 32'h20);
        bus(1, 8'h08, 32'h10);
        pins(6'h3f);
        chk({26'h0, pinOut}, 32'h3f);
        bus(0, 8'h18, 0);
        chk(rd, 32'h0);
        bus(1, 8'h18, 32'h0);
        bus(0, 8'h00, 0);
        chk(rd, 32'h3f);
        $display("test boot done");
    endtask
    task t_shadow;
        bus(1, 8'h00, 32'h01);
        pins(6'h01);
        bus(1, 8'h00, 32'h20);
        pins(6'h20);
        bus(1, 8'h04, 32'h21);
        pins(6'h20);
        bus(1, 8'h08, 32'h01);
        pins(6'h21);
        bus(1, 8'h04, 32'h01);
        bus(1, 8'h08, 32'h01);
        pins(6'h01);
        $display("test shadow done");
    endtask
    // Software keeps a gap between direct reads; only one here
    task t_direct;
        bus(1, 8'h00, 32'h24);
        bus(1, 8'h14, 32'h02);
        leftPressed <= 1'b1;
        bus(1, 8'h08, 32'h04);
        cnt = 0;
        for (int i = 0; i < 40 && irq !== 1'b1; i++)
        begin
            @(posedge clk);
            cnt += (pinOe[5] === 1'b0);
        end
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, cnt > 0 && cnt < 10}, 32'h1);
        pins(6'h24);
        bus(0, 8'h0c, 0);
        chk(rd & 32'hc, 32'h4);
        bus(1, 8'h10, 32'h02);
        leftPressed <= 1'b0;
        pins(6'h24);
        chk({31'h0, irq}, 32'h0);
        $display("test direct done");
    endtask
    task t_poll;
        rightPressed <= 1'b1;
        bus(1, 8'h14, 32'h01);
        bus(1, 8'h08, 32'h02);
        for (int i = 0; i < 3 * POLL && irq !== 1'b1; i++)
            @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(0, 8'h0c, 0);
        chk(rd & 32'h3, 32'h2);
        bus(1, 8'h10, 32'h01);
        repeat (2 * POLL) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rightPressed <= 1'b0;
        for (int i = 0; i < 3 * POLL && irq !== 1'b1; i++)
            @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(0, 8'h0c, 0);
        chk(rd & 32'h3, 32'h0);
        bus(1, 8'h10, 32'h01);
        chk({31'h0, irq}, 32'h0);
        $display("test poll done");
    endtask
    // Mid-run reset with the boot-dark byte cleared: pins light at once
    task t_reset;
        @(posedge clk);
        reset <= 1'b1;
        darkByte <= 1'b0;
        darkValid <= 1'b0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bus(0, 8'h08, 0);
        chk(rd & 32'h33, 32'h0);
        darkValid <= 1'b1;
        bus(1, 8'h00, 32'h09);
        pins(6'h09);
        bus(0, 8'h08, 0);
        chk(rd & 32'h30, 32'h20);
        $display("test reset done");
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        reset = 1'b1;
        {wbCyc, wbStb, wbWe, leftPressed, rightPressed} = 5'h0;
        wbAdr = 8'h0;
        wbDatW = 32'h0;
        wbSel = 4'h0;
        {darkByte, darkValid} = 2'h3;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        t_boot;
        t_shadow;
        t_direct;
        t_poll;
        t_reset;
        conclude;
    end
    // Watchdog well beyond the expected thousand or so cycles
    initial
    begin
        #200000;
        $display("[ERR] %0t watchdog expired", $time);
        bad_count++;
        conclude;
    end
endmodule // tb_top
